// ==== verilog/swcfg_regs.sv ====
// Configuration register bank of a four-input video link switch.
// Assumes a serial slave elsewhere presents decoded register accesses
// on the core clock; strap pins are asynchronous board levels.
// What this block does
// RL1: EQ bit clear 6 dB, set 12 dB
// RL2: EQ bits map B, A, C reversed, D reversed
// RL3: Two-bit pre-emphasis for all outputs
// RL4: Termination bit: 0 off, 1 on
// RL5: Current bit: 0 is 10 mA, 1 20 mA
// RL6: Strap pins load the configuration registers
// RL7: Straps rule only until first serial access
// RL8: Board ties straps statically high or low
// RL9: Mode register: enable, zeros, source select
// RL10: Termination pulse registers all zero when strapped
// RL11: All equalizer bits equal the eq strap
// RL12: Transmitter register from boost, term, current straps
// RL13: Enable 0 standby, 1 channels on
// RL14: Source select 00 A .. 11 D
// RL15: Aux switch on, quad, same source select
// RL16: Receiver termination held on when strapped
// RL17: Sync straps; strap mode ends on access
// Trade-off: every control output is registered, so a write reaches
// the controls one edge after the register image takes it.
// Hazard: a strap that moves close to the first access may be caught
// by either synchroniser stage; the board is expected to hold them still.
`timescale 1ns/1ps
module swcfg_regs (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Strap pins (asynchronous, held static by the board)
    input wire logic strap_hs_enable_i,
    input wire logic [1:0] strap_source_sel_i,
    input wire logic strap_eq_level_i,
    input wire logic [1:0] strap_boost_level_i,
    input wire logic strap_output_term_i,
    input wire logic strap_output_current_i,
    // Serial register access port
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [2:0] acc_index_i,
    input wire logic [7:0] acc_wdata_i,
    output logic [7:0] acc_rdata_o,
    // Decoded controls toward the analog blocks
    output logic strap_mode_o,
    output logic hs_enable_o,
    output logic [1:0] hs_source_sel_o,
    output logic aux_enable_o,
    output logic [1:0] aux_source_sel_o,
    output logic rx_term_on_o,
    output logic [15:0] input_eq_level_bits_o,
    output logic [15:0] term_pulse_bits_o,
    output logic [1:0] output_boost_level_o,
    output logic output_term_on_o,
    output logic output_current_sel_o
);

    // Strap synchroniser stages: first stage feeds only the second
    logic [7:0] strap_s1_r;
    logic [7:0] strap_s2_r;
    // Strap mode flag, set at reset
    logic strap_mode_r;
    // Software-written register images
    logic [7:0] hs_modes_r;
    logic [7:0] aux_modes_r;
    logic [7:0] rx_set_r;
    logic [7:0] term_ab_r;
    logic [7:0] term_cd_r;
    logic [7:0] eq_ab_r;
    logic [7:0] eq_cd_r;
    logic [7:0] tx_set_r;
    // Effective register values, strap or software
    logic [7:0] hs_modes_eff;
    logic [7:0] aux_modes_eff;
    logic [7:0] rx_set_eff;
    logic [7:0] term_ab_eff;
    logic [7:0] term_cd_eff;
    logic [7:0] eq_ab_eff;
    logic [7:0] eq_cd_eff;
    logic [7:0] tx_set_eff;
    // Named strap fields after synchronisation
    logic s_en;
    logic [1:0] s_src;
    logic s_eq;
    logic [1:0] s_boost;
    logic s_oterm;
    logic s_ocur;

    // The equalizer and pulse bytes already follow the lane order of the
    // channel map (C and D counted down), so nothing is reordered on the way out.

    // Two-stage strap synchroniser; straps are static, so plain levels suffice.
    // The pins have no timing relation to the core clock, hence both stages.
    // RL17: sync strap pins
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Clear both stages so no stale level outlives a reset
            strap_s1_r <= swcfg_pkg::SWCFG_ZERO;
            strap_s2_r <= swcfg_pkg::SWCFG_ZERO;
        end else begin
            // Packed as {en, src, eq, boost, term, cur}; only stage two reads stage one
            strap_s1_r <= {strap_hs_enable_i, strap_source_sel_i, strap_eq_level_i,
                           strap_boost_level_i, strap_output_term_i, strap_output_current_i};
            strap_s2_r <= strap_s1_r;
        end
    end

    // Split the synchronised strap vector into fields
    // Field order follows the packing in the synchroniser above;
    // named fields keep the register layouts below readable.
    // RL8: static board levels
    always_comb begin
        s_en = strap_s2_r[7];
        s_src = strap_s2_r[6:5];
        s_eq = strap_s2_r[4];
        s_boost = strap_s2_r[3:2];
        s_oterm = strap_s2_r[1];
        s_ocur = strap_s2_r[0];
    end

    // Strap mode: set by reset, cleared by any serial access, read or write.
    // Hazard: an access in the first two edges after reset freezes the
    // synchroniser's reset value, not the pins; software must wait that long.
    // RL7: first access ends straps
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Every reset hands control back to the pins
            strap_mode_r <= 1'b1;
        end else if (acc_valid_i) begin
            // Sticky until the next reset, reads included
            strap_mode_r <= 1'b0;
        end
    end

    // Register images; on the first access they take over from the strap
    // values so a read-modify-write starts from what the pins had set.
    // Unused bits are stored as written and read back unchanged.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Zero is never seen while strapped; the snapshot replaces it
            hs_modes_r <= swcfg_pkg::SWCFG_ZERO;
            aux_modes_r <= swcfg_pkg::SWCFG_ZERO;
            rx_set_r <= swcfg_pkg::SWCFG_ZERO;
            term_ab_r <= swcfg_pkg::SWCFG_ZERO;
            term_cd_r <= swcfg_pkg::SWCFG_ZERO;
            eq_ab_r <= swcfg_pkg::SWCFG_ZERO;
            eq_cd_r <= swcfg_pkg::SWCFG_ZERO;
            tx_set_r <= swcfg_pkg::SWCFG_ZERO;
        end else if (acc_valid_i) begin
            // Snapshot the effective values first, so the first access
            // freezes whatever the straps were showing
            hs_modes_r <= hs_modes_eff;
            aux_modes_r <= aux_modes_eff;
            rx_set_r <= rx_set_eff;
            term_ab_r <= term_ab_eff;
            term_cd_r <= term_cd_eff;
            eq_ab_r <= eq_ab_eff;
            eq_cd_r <= eq_cd_eff;
            tx_set_r <= tx_set_eff;
            // Then the write itself overrides its target
            if (acc_write_i) begin
                if (acc_index_i == swcfg_pkg::SWCFG_IDX_HS_MODES) begin
                    // Enable, switching mode and source select
                    hs_modes_r <= acc_wdata_i;
                end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_AUX_MODES) begin
                    // Auxiliary switch enable, mode and source
                    aux_modes_r <= acc_wdata_i;
                end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_RX_SET) begin
                    // Input termination select
                    rx_set_r <= acc_wdata_i;
                end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_TERM_AB) begin
                    // Pulse bits for sources A and B
                    term_ab_r <= acc_wdata_i;
                end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_TERM_CD) begin
                    // Pulse bits for sources C and D
                    term_cd_r <= acc_wdata_i;
                end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_EQ_AB) begin
                    // Equalizer bits for sources A and B
                    eq_ab_r <= acc_wdata_i;
                end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_EQ_CD) begin
                    // Equalizer bits for sources C and D
                    eq_cd_r <= acc_wdata_i;
                end else begin
                    // Only the transmitter settings index is left
                    tx_set_r <= acc_wdata_i;
                end
            end
        end
    end

    // Effective register contents: straps while in strap mode
    // Pure selection, no state: both modes share one read and output path
    // RL6: straps load registers
    always_comb begin
        if (strap_mode_r) begin
            // Bit 7 reads zero and bits 5:2 hold quad mode in both mode registers
            // RL9: mode register layout
            hs_modes_eff = {1'b0, s_en, swcfg_pkg::SWCFG_QUAD_MODE, s_src};
            // RL15: aux always on, quad
            aux_modes_eff = {1'b0, 1'b1, swcfg_pkg::SWCFG_QUAD_MODE, s_src};
            // RL16: input termination on
            rx_set_eff = swcfg_pkg::SWCFG_ZERO;
            rx_set_eff[swcfg_pkg::SWCFG_RXTERM_BIT] = 1'b1;
            // RL10: no termination pulses
            term_ab_eff = swcfg_pkg::SWCFG_TERM_PULSE_OFF;
            term_cd_eff = swcfg_pkg::SWCFG_TERM_PULSE_OFF;
            // RL11: one eq for all
            eq_ab_eff = {8{s_eq}};
            eq_cd_eff = {8{s_eq}};
            // RL12: transmitter from straps
            tx_set_eff = {4'h0, s_boost, s_oterm, s_ocur};
        end else begin
            // Register mode: the software images rule every field
            hs_modes_eff = hs_modes_r;
            aux_modes_eff = aux_modes_r;
            rx_set_eff = rx_set_r;
            term_ab_eff = term_ab_r;
            term_cd_eff = term_cd_r;
            eq_ab_eff = eq_ab_r;
            eq_cd_eff = eq_cd_r;
            tx_set_eff = tx_set_r;
        end
    end

    // Read data, registered; shows the value before this access's write.
    // A read in the strap-exit cycle returns the strap values.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Clean read data after reset
            acc_rdata_o <= swcfg_pkg::SWCFG_ZERO;
        end else if (acc_valid_i && !acc_write_i) begin
            // Only reads move the read data; writes leave it holding
            if (acc_index_i == swcfg_pkg::SWCFG_IDX_HS_MODES) begin
                // High speed modes
                acc_rdata_o <= hs_modes_eff;
            end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_AUX_MODES) begin
                // Auxiliary modes
                acc_rdata_o <= aux_modes_eff;
            end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_RX_SET) begin
                // Receiver settings
                acc_rdata_o <= rx_set_eff;
            end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_TERM_AB) begin
                // Pulse bits A and B
                acc_rdata_o <= term_ab_eff;
            end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_TERM_CD) begin
                // Pulse bits C and D
                acc_rdata_o <= term_cd_eff;
            end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_EQ_AB) begin
                // Equalizer A and B
                acc_rdata_o <= eq_ab_eff;
            end else if (acc_index_i == swcfg_pkg::SWCFG_IDX_EQ_CD) begin
                // Equalizer C and D
                acc_rdata_o <= eq_cd_eff;
            end else begin
                // Transmitter settings
                acc_rdata_o <= tx_set_eff;
            end
        end
    end

    // Decoded controls, registered so every output comes from a flip-flop.
    // Trade-off: this costs one edge, so a write reaches the controls one
    // edge after it is taken, and the strap flag output drops one edge after.
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            // Quiet controls while in reset, strap flag raised
            strap_mode_o <= 1'b1;
            hs_enable_o <= 1'b0;
            hs_source_sel_o <= 2'h0;
            aux_enable_o <= 1'b0;
            aux_source_sel_o <= 2'h0;
            rx_term_on_o <= 1'b0;
            input_eq_level_bits_o <= 16'h0000;
            term_pulse_bits_o <= 16'h0000;
            output_boost_level_o <= 2'h0;
            output_term_on_o <= 1'b0;
            output_current_sel_o <= 1'b0;
        end else begin
            strap_mode_o <= strap_mode_r;
            // RL13: enable, standby when 0
            hs_enable_o <= hs_modes_eff[swcfg_pkg::SWCFG_EN_BIT];
            // RL14: source A to D
            hs_source_sel_o <= hs_modes_eff[swcfg_pkg::SWCFG_SRC_LSB +: 2];
            // Auxiliary switch uses the same field layout
            aux_enable_o <= aux_modes_eff[swcfg_pkg::SWCFG_EN_BIT];
            aux_source_sel_o <= aux_modes_eff[swcfg_pkg::SWCFG_SRC_LSB +: 2];
            // Input termination for all high speed inputs
            rx_term_on_o <= rx_set_eff[swcfg_pkg::SWCFG_RXTERM_BIT];
            // RL2: channel bit mapping
            // RL1: per-channel eq level
            input_eq_level_bits_o <= {eq_cd_eff, eq_ab_eff};
            // Pulse bits share the lane order of the eq bits
            term_pulse_bits_o <= {term_cd_eff, term_ab_eff};
            // Pre-emphasis and output drive, shared by all outputs
            // RL3: global pre-emphasis
            output_boost_level_o <= tx_set_eff[swcfg_pkg::SWCFG_BOOST_LSB +: 2];
            // RL4: output termination
            output_term_on_o <= tx_set_eff[swcfg_pkg::SWCFG_OTERM_BIT];
            // RL5: output current
            output_current_sel_o <= tx_set_eff[swcfg_pkg::SWCFG_OCUR_BIT];
        end
    end

endmodule

// ==== verilog/swcfg_pkg.sv ====
// Constants for the switch configuration register bank with strap load.
// Assumes a single 20 MHz core clock and a synchronous active-high reset.
package swcfg_pkg;
    // Register indices on the serial access port
    localparam logic [2:0] SWCFG_IDX_HS_MODES = 3'h0;
    localparam logic [2:0] SWCFG_IDX_AUX_MODES = 3'h1;
    localparam logic [2:0] SWCFG_IDX_RX_SET = 3'h2;
    localparam logic [2:0] SWCFG_IDX_TERM_AB = 3'h3;
    localparam logic [2:0] SWCFG_IDX_TERM_CD = 3'h4;
    localparam logic [2:0] SWCFG_IDX_EQ_AB = 3'h5;
    localparam logic [2:0] SWCFG_IDX_EQ_CD = 3'h6;
    localparam logic [2:0] SWCFG_IDX_TX_SET = 3'h7;
    // Field positions
    localparam int SWCFG_EN_BIT = 6;
    localparam int SWCFG_RXTERM_BIT = 0;
    localparam int SWCFG_BOOST_LSB = 2;
    localparam int SWCFG_OTERM_BIT = 1;
    localparam int SWCFG_OCUR_BIT = 0;
    localparam int SWCFG_SRC_LSB = 0;
    // Fixed values while strapped
    localparam logic [3:0] SWCFG_QUAD_MODE = 4'h0;
    localparam logic [7:0] SWCFG_TERM_PULSE_OFF = 8'h00;
    localparam logic [7:0] SWCFG_ZERO = 8'h00;
    // Output pre-emphasis encodings
    typedef enum logic [1:0] {
        SWCFG_BOOST_NONE = 2'h0, // 0 dB
        SWCFG_BOOST_LOW = 2'h1,  // 2 dB
        SWCFG_BOOST_MED = 2'h2,  // 4 dB
        SWCFG_BOOST_HIGH = 2'h3  // 6 dB
    } swcfg_boost_t;
endpackage

// ==== bench/swcfg_regs_assertions.sv ====
// Port checker for the switch configuration register bank.
// Assumes one core clock and the bank's synchronous reset.
`timescale 1ns/1ps
module swcfg_regs_assertions (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic rst_i,
    // Straps and access port
    input wire logic strap_hs_enable_i,
    input wire logic [1:0] strap_source_sel_i,
    input wire logic strap_eq_level_i,
    input wire logic [1:0] strap_boost_level_i,
    input wire logic strap_output_term_i,
    input wire logic strap_output_current_i,
    input wire logic acc_valid_i,
    input wire logic acc_write_i,
    input wire logic [2:0] acc_index_i,
    input wire logic [7:0] acc_wdata_i,
    // Decoded controls
    input wire logic strap_mode_o,
    input wire logic hs_enable_o,
    input wire logic [1:0] hs_source_sel_o,
    input wire logic aux_enable_o,
    input wire logic [1:0] aux_source_sel_o,
    input wire logic rx_term_on_o,
    input wire logic [15:0] input_eq_level_bits_o,
    input wire logic [15:0] term_pulse_bits_o,
    input wire logic [1:0] output_boost_level_o,
    input wire logic output_term_on_o,
    input wire logic output_current_sel_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Cycles since reset; straps need three edges to settle
    // Strap-driven outputs trail the pins by three edges, so pins are taken three edges back
    logic [2:0] age_r;
    always_ff @(posedge core_clk_i) begin
        if (rst_i) age_r <= 3'h0;
        else if (age_r != 3'h7) age_r <= age_r + 3'h1;
    end
    wire settled = strap_mode_o && (age_r > 3'h3);
    // One access, and one write to a given index
    sequence acc_s; acc_valid_i; endsequence
    sequence wr_s(logic [2:0] idx); acc_valid_i && acc_write_i && acc_index_i == idx; endsequence
    eq_strap_a: assert property (settled |-> input_eq_level_bits_o == {16{$past(strap_eq_level_i, 3)}})
        else $error("eq bits differ from strap");
    pulse_off_a: assert property (strap_mode_o |-> term_pulse_bits_o == 16'h0000)
        else $error("pulse bits set while strapped");
    rx_term_a: assert property (settled |-> rx_term_on_o)
        else $error("rx termination off while strapped");
    tx_strap_a: assert property (settled |-> output_boost_level_o == $past(strap_boost_level_i, 3) &&
        output_term_on_o == $past(strap_output_term_i, 3) &&
        output_current_sel_o == $past(strap_output_current_i, 3))
        else $error("tx controls differ from strap");
    hs_strap_a: assert property (settled |-> hs_enable_o == $past(strap_hs_enable_i, 3) &&
        hs_source_sel_o == $past(strap_source_sel_i, 3)) else $error("hs controls differ from strap");
    aux_strap_a: assert property (settled |-> aux_enable_o && aux_source_sel_o == $past(strap_source_sel_i, 3))
        else $error("aux controls differ from strap");
    // The strap flag output drops one edge after the access is taken, checked two edges after
    strap_exit_a: assert property (acc_s |-> ##2 !strap_mode_o)
        else $error("strap mode kept after access");
    strap_sticky_a: assert property (!strap_mode_o |=> !strap_mode_o)
        else $error("strap mode came back without reset");
    tx_write_a: assert property (wr_s(swcfg_pkg::SWCFG_IDX_TX_SET) |-> ##2
        ({4'h0, output_boost_level_o, output_term_on_o, output_current_sel_o} == ($past(acc_wdata_i, 2) & 8'h0f)))
        else $error("tx controls differ from write");
endmodule
bind swcfg_regs swcfg_regs_assertions i_swcfg_regs_assertions (.*);

// ==== bench/swcfg_strap_board.sv ====
// Board model: ties each strap pin to a level.
// Assumes the bench changes levels only during reset or to test strap release.
`timescale 1ns/1ps
module swcfg_strap_board (
    // Levels {en, src[1:0], eq, boost[1:0], term, cur}
    input wire logic [7:0] level_i,
    // Strap pins
    output logic en_o,
    output logic [1:0] src_o,
    output logic eq_o,
    output logic [1:0] boost_o,
    output logic term_o,
    output logic cur_o
);
    assign {en_o, src_o, eq_o, boost_o, term_o, cur_o} = level_i;
endmodule

// ==== bench/swcfg_regs_tb_top.sv ====
// Bench for the switch configuration register bank.
// Assumes a 20 MHz core clock and the board strap model.
`timescale 1ns/1ps
module swcfg_regs_tb_top;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic acc_valid_i = 1'b0;
    logic acc_write_i = 1'b0;
    logic [2:0] acc_index_i = 3'h0;
    logic [7:0] acc_wdata_i = 8'h00;
    logic [7:0] lvl = 8'h00; // Board levels
    logic strap_hs_enable_i, strap_eq_level_i, strap_output_term_i, strap_output_current_i;
    logic [1:0] strap_source_sel_i, strap_boost_level_i, hs_source_sel_o, aux_source_sel_o, output_boost_level_o;
    logic strap_mode_o, hs_enable_o, aux_enable_o, rx_term_on_o, output_term_on_o, output_current_sel_o;
    logic [7:0] acc_rdata_o, v[8];
    logic [15:0] input_eq_level_bits_o, term_pulse_bits_o;
    logic [7:0] notes[$]; // Expected read data, oldest first
    logic pend = 1'b0;
    int mismatches = 0;
    int checks = 0;
    swcfg_regs i_swcfg_regs (.*);
    swcfg_strap_board i_swcfg_strap_board (.level_i(lvl), .en_o(strap_hs_enable_i), .src_o(strap_source_sel_i),
        .eq_o(strap_eq_level_i), .boost_o(strap_boost_level_i), .term_o(strap_output_term_i),
        .cur_o(strap_output_current_i));
    // 50 ns clock
    initial forever #25 core_clk_i = ~core_clk_i;
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until the next edge takes it; back to back allowed
    task automatic acc(input logic wr, input logic [2:0] idx, input logic [7:0] d);
        @(posedge core_clk_i);
        #5;
        acc_valid_i = 1'b1;
        acc_write_i = wr;
        acc_index_i = idx;
        acc_wdata_i = d;
    endtask
    task automatic idle(input int n);
        @(posedge core_clk_i);
        #5;
        acc_valid_i = 1'b0;
        repeat (n) @(posedge core_clk_i);
        #5;
    endtask
    // Register image while strapped
    function automatic logic [7:0] strap_reg(input logic [2:0] idx, input logic [7:0] s);
        case (idx)
            3'h0: return {1'b0, s[7], 4'h0, s[6:5]};
            3'h1: return {2'h1, 4'h0, s[6:5]};
            3'h2: return 8'h01;
            3'h5, 3'h6: return {8{s[4]}};
            3'h7: return {4'h0, s[3:0]};
            default: return 8'h00;
        endcase
    endfunction
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Read data lands on the edge that takes the read and is checked at the next falling edge
    always @(negedge core_clk_i) begin
        if (pend) begin
            if (notes.size() == 0) chk("note queue", 16'h0001, 16'h0000);
            else chk("read data", {8'h00, notes.pop_front()}, {8'h00, acc_rdata_o});
        end
        pend <= acc_valid_i && !acc_write_i;
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge core_clk_i);
        mismatches++;
        conclude();
    end
    initial begin
        void'($urandom(6820));
        // Strap load per reset, then first access ends strap mode
        for (int it = 0; it < 8; it++) begin
            rst_i = 1'b1;
            lvl = 8'($urandom());
            lvl[6:5] = ~it[1:0];
            lvl[3:2] = it[1:0];
            idle(16);
            rst_i = 1'b0;
            idle(4);
            chk("strap flag", 16'h0001, {15'h0, strap_mode_o});
            chk("eq bits", {16{lvl[4]}}, input_eq_level_bits_o);
            chk("tx ctl", {12'h0, lvl[3:0]}, {12'h0, output_boost_level_o, output_term_on_o, output_current_sel_o});
            chk("hs ctl", {13'h0, lvl[7:5]}, {13'h0, hs_enable_o, hs_source_sel_o});
            chk("aux ctl", {14'h1, lvl[6:5]}, {13'h0, aux_enable_o, aux_source_sel_o});
            chk("rx term", {15'h0, 1'b1}, {15'h0, rx_term_on_o});
            notes.push_back(strap_reg(it[2:0], lvl));
            acc(1'b0, it[2:0], 8'($urandom()));
            lvl = ~lvl;
            idle(4);
            chk("released flag", 16'h0000, {15'h0, strap_mode_o});
            chk("eq kept", {16{~lvl[4]}}, input_eq_level_bits_o);
        end
        // Serial writes then reads, all back to back
        for (int i = 0; i < 8; i++) begin
            v[i] = 8'($urandom());
            acc(1'b1, 3'(i), v[i]);
        end
        for (int i = 0; i < 8; i++) begin
            notes.push_back(v[i]);
            acc(1'b0, 3'(i), 8'($urandom()));
        end
        idle(2);
        chk("eq map", {v[6], v[5]}, input_eq_level_bits_o);
        chk("pulse map", {v[4], v[3]}, term_pulse_bits_o);
        chk("tx write", {12'h0, v[7][3:0]}, {12'h0, output_boost_level_o, output_term_on_o, output_current_sel_o});
        chk("hs write", {13'h0, v[0][6], v[0][1:0]}, {13'h0, hs_enable_o, hs_source_sel_o});
        chk("aux write", {13'h0, v[1][6], v[1][1:0]}, {13'h0, aux_enable_o, aux_source_sel_o});
        chk("rx write", {15'h0, v[2][0]}, {15'h0, rx_term_on_o});
        conclude();
    end
endmodule
